//--- common/pin_port_regs.vh
`ifndef PIN_PORT_REGS_VH
`define PIN_PORT_REGS_VH
// printed offsets are not multiples of four: they are indices, byte address is index*4
`define PIN_DIRECTION_IDX 16'hffcd
`define PIN_OUTPUT_VALUE_IDX 16'hffcf
`define PIN_DIRECTION_RST 8'hf0
`define PIN_OUTPUT_VALUE_RST 8'he0
`define PORT_WIDTH 5
`define DIR_READ_VALUE 8'hff
`define RESERVED_ONES 3'b111
`define REFRESH_PIN 0
`endif

//--- rtl/pin_sync.v
`timescale 1ns/1ps
// two-stage synchroniser, one per bit
module pin_sync #(
  parameter WIDTH = 5
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          // idle high, so active-low requests do not pulse after reset
          meta_ff[i] <= 1'b1;
          sync_ff[i] <= 1'b1;
        end
        else
        begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_ff;
endmodule // pin_sync

//--- rtl/cs_port.v
// Contract
// - five pins: chip selects, refresh, interrupt inputs
// - pin function ignores operating mode
// - write-only 8-bit direction register
// - direction one drives chip-select on pins 4..1
// - pin 0 plain output when refresh off
// - direction zero makes pin input, except pin 0 while refresh is on
// - direction register reads all ones
// - direction resets to f0, kept in soft standby
// - read/write data register for pins 4..0
// - read returns latch if output, else pin
// - data bits 7..5 read one, ignore writes
// - data resets to e0, kept in soft standby
// - pins 4..1 select by own direction bit
// - pins 3..0 always feed interrupt inputs
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "pin_port_regs.vh"
module cs_port (
  input wire pclk,
  input wire presetn,
  input wire hw_standby,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [4:0] pin_in,
  output reg [4:0] pin_out,
  output reg [4:0] pin_oe,
  input wire refresh_pin_enable,
  input wire refresh_strobe_n,
  input wire [3:0] chip_select_n,
  output reg [3:0] irq_request_n
);
  localparam [17:0] DIR_WORD = {2'b00, `PIN_DIRECTION_IDX};
  localparam [17:0] DAT_WORD = {2'b00, `PIN_OUTPUT_VALUE_IDX};

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin levels
  wire [4:0] pin_sync_lvl;
  pin_sync #(.WIDTH(`PORT_WIDTH)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_in),
    .sync_out(pin_sync_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] pin_direction_ff;
  reg [4:0] pin_output_value_ff;
  wire [17:0] word_addr = paddr[19:2];
  wire access = psel && penable;
  wire hit_dir = (word_addr == DIR_WORD);
  wire hit_dat = (word_addr == DAT_WORD);
  wire wr_dir = access && pwrite && hit_dir && pstrb[0];
  wire wr_dat = access && pwrite && hit_dat && pstrb[0];

  // hardware standby reloads like reset; software standby needs nothing here
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_direction_ff <= `PIN_DIRECTION_RST;
      pin_output_value_ff <= 5'h00;
    end
    else if (hw_standby)
    begin
      pin_direction_ff <= `PIN_DIRECTION_RST;
      pin_output_value_ff <= 5'h00;
    end
    else
    begin
      if (wr_dir)
        pin_direction_ff <= pwdata[7:0];
      if (wr_dat)
        pin_output_value_ff <= pwdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and apb answer (zero wait states)
  reg [7:0] nxt_rd;
  always @*
  begin
    nxt_rd = 8'h00;
    if (hit_dir)
      nxt_rd = `DIR_READ_VALUE;
    else if (hit_dat)
      nxt_rd = {`RESERVED_ONES,
                (pin_direction_ff[4:0] & pin_output_value_ff) |
                (~pin_direction_ff[4:0] & pin_sync_lvl)};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit_dir || hit_dat);
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, nxt_rd} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin muxing; next values use the write data so pins update on the write edge
  wire [7:0] dir_now = wr_dir ? pwdata[7:0] : pin_direction_ff;
  wire [4:0] dat_now = wr_dat ? pwdata[4:0] : pin_output_value_ff;
  reg [4:0] nxt_out;
  reg [4:0] nxt_oe;
  integer k;
  always @*
  begin
    nxt_out = 5'h00;
    nxt_oe = 5'h00;
    for (k = 1; k < 5; k = k + 1)
    begin
      nxt_oe[k] = (!hw_standby) && dir_now[k];
      nxt_out[k] = chip_select_n[4-k];
    end
    if (refresh_pin_enable)
    begin
      nxt_oe[0] = !hw_standby;
      nxt_out[0] = refresh_strobe_n;
    end
    else
    begin
      nxt_oe[0] = (!hw_standby) && dir_now[0];
      nxt_out[0] = dat_now[0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 5'h00;
      pin_oe <= 5'h00;
      irq_request_n <= 4'hf;
    end
    else
    begin
      pin_out <= nxt_out;
      pin_oe <= nxt_oe;
      irq_request_n <= pin_sync_lvl[3:0];
    end
  end
endmodule // cs_port

//--- tb/cs_port_asserts.sv
`timescale 1ns/1ps
module cs_port_asserts (
  input wire pclk, presetn, hw_standby, psel, penable, pwrite, pready,
  input wire [31:0] paddr, pwdata, prdata,
  input wire [3:0] pstrb, chip_select_n, irq_request_n,
  input wire [4:0] pin_in, pin_out, pin_oe,
  input wire refresh_pin_enable, refresh_strobe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup; psel && !penable; endsequence
  sequence done(a, w); pready && pwrite == w && paddr == a; endsequence
  ////////////////////////////////
  chk_ready_next: assert property (setup |=> pready)
    else $error("no ready");
  chk_dir_ones: assert property (done(32'h3ff34, 0) |-> prdata[7:0] == 8'hff)
    else $error("dir read");
  chk_resv_ones: assert property (done(32'h3ff3c, 0) |-> prdata[7:5] == 3'b111)
    else $error("reserved bits");
  chk_dir_input: assert property (pready && pwrite && paddr == 32'h3ff34
    && pstrb[0] && pwdata[4:1] == 0 |=> pin_oe[4:1] == 0) else $error("pin driven");
  chk_irq_feed: assert property ($past(presetn, 3)
    |-> irq_request_n == $past(pin_in[3:0], 3)) else $error("irq level");
  chk_cs_drive: assert property ($past(presetn) && pin_oe[4]
    |-> pin_out[4] == $past(chip_select_n[0])) else $error("chip select");
  chk_refresh_pin: assert property ($past(presetn && refresh_pin_enable && !hw_standby)
    |-> pin_oe[0] && pin_out[0] == $past(refresh_strobe_n)) else $error("refresh");
  chk_standby_off: assert property (hw_standby |=> pin_oe == 5'h0)
    else $error("standby drive");
endmodule // cs_port_asserts
bind cs_port cs_port_asserts u_chk (.*);

//--- tb/pin_board.sv
`timescale 1ns/1ps
module pin_board (
  input wire [4:0] pin_out,
  input wire [4:0] pin_oe,
  input wire [4:0] ext,
  output wire [4:0] pin_in
);
  // released pins take the board level, never the last driven one
  assign pin_in = pin_oe & pin_out | ~pin_oe & ext;
endmodule // pin_board

//--- tb/five_bit_port_with_chip_select_mux_tb.sv
`timescale 1ns/1ps
module five_bit_port_with_chip_select_mux_tb;
  reg pclk = 0, presetn = 0, hw_standby = 0, psel = 0, penable = 0, pwrite = 0;
  reg refresh_pin_enable = 0, refresh_strobe_n = 1, er;
  reg [31:0] paddr = 0, pwdata = 0, r = 32'h2e28a2ef, rd;
  reg [3:0] pstrb = 0, chip_select_n = 4'hf;
  reg [4:0] ext = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [4:0] pin_in, pin_out, pin_oe;
  wire [3:0] irq_request_n;
  int err_count = 0, checks = 0, d = 8'hf0, q = 8'he0, i;
  always #25 pclk = ~pclk;
  cs_port u_cs_port (.pclk, .presetn, .hw_standby, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
    .refresh_pin_enable, .refresh_strobe_n, .chip_select_n, .irq_request_n);
  pin_board u_pin_board (.pin_out, .pin_oe, .ext, .pin_in);
  ////////////////////////////////
  function [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task ck(input string n, input [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task apb(input w, input [31:0] a, dt);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (w && pstrb[0] && !er && a[3]) q = dt[4:0];
    if (w && pstrb[0] && !er && !a[3]) d = dt[7:0];
  endtask
  task ckall;
    reg [4:0] oe, o, lv;
    oe = {d[4:1], d[0] | refresh_pin_enable};
    o = {chip_select_n[0], chip_select_n[1], chip_select_n[2], chip_select_n[3], 1'b0};
    o[0] = refresh_pin_enable ? refresh_strobe_n : q[0];
    lv = oe & o | ~oe & ext;
    repeat (4) @(posedge pclk);
    ck("oe", pin_oe, oe);
    ck("out", pin_out & oe, o & oe);
    ck("irq", irq_request_n, lv[3:0]);
    apb(0, 32'h3ff34, 0);
    ck("dir", rd, 32'hff);
    apb(0, 32'h3ff3c, 0);
    ck("data", rd, 8'he0 | d & q | ~d & lv);
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    ckall;
    pstrb <= 4'hf;
    apb(1, 32'h3ff34, 0);
    ckall;
    for (i = 0; i < 24; i++)
    begin
      r = xs(r);
      {ext, chip_select_n, refresh_pin_enable, refresh_strobe_n} <= r[10:0];
      pstrb <= r[31:28];
      apb(1, 32'h3ff34, r >> 11);
      apb(1, 32'h3ff3c, r >> 16);
      ckall;
    end
    apb(0, 32'h100, 0);
    ck("err", er, 1);
    hw_standby <= 1;
    repeat (2) @(posedge pclk);
    ck("standby", pin_oe, 0);
    d = 8'hf0;
    q = 8'he0;
    hw_standby <= 0;
    ckall;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule // five_bit_port_with_chip_select_mux_tb
